/* File: core/block_ram.sv */
// Embedded block RAM: shared lane storage with two configurable ports.
`timescale 1ns/1ps
`default_nettype none
`include "ram_map.svh"

module block_ram
   import ram_pkg::*;
#(
   parameter ram_mode_e MODE      = TRUE_DUAL,
   parameter rdw_e      RDW       = RDW_OLD,
   parameter int        WIDTH_A   = 36,
   parameter int        WIDTH_B   = 36,
   parameter bit        OUT_REG_A = 1'b0,
   parameter bit        OUT_REG_B = 1'b0,
   parameter bit        PACKED    = 1'b0,
   localparam int       DIV       = PACKED ? 2 : 1,
   localparam int       DEPTH_A   = (((WIDTH_A % 9) == 0) ? `TOTAL_BITS : `DATA_BITS)
                                    / WIDTH_A / DIV,
   localparam int       DEPTH_B   = (((WIDTH_B % 9) == 0) ? `TOTAL_BITS : `DATA_BITS)
                                    / WIDTH_B / DIV,
   localparam int       AW_A      = $clog2(DEPTH_A),
   localparam int       AW_B      = $clog2(DEPTH_B)
)
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire logic                 clken_in_a,
   input  wire logic                 clken_out_a,
   input  wire logic                 aclr_a,
   input  wire logic [AW_A-1:0]      addr_a,
   input  wire logic                 addr_stall_a,
   input  wire logic                 wren_a,
   input  wire logic                 rden_a,
   input  wire logic [`BE_W-1:0]     be_a = `BE_ALL,
   input  wire logic [WIDTH_A-1:0]   din_a,
   output logic      [WIDTH_A-1:0]   q_a,
   input  wire logic                 clken_in_b,
   input  wire logic                 clken_out_b,
   input  wire logic                 aclr_b,
   input  wire logic [AW_B-1:0]      addr_b,
   input  wire logic                 addr_stall_b,
   input  wire logic                 wren_b,
   input  wire logic                 rden_b,
   input  wire logic [`BE_W-1:0]     be_b = `BE_ALL,
   input  wire logic [WIDTH_B-1:0]   din_b,
   output logic      [WIDTH_B-1:0]   q_b
);

   // An illegal shape disables both ports rather than half-working.
   localparam bit  SHAPES  = shape_ok(WIDTH_A) && shape_ok(WIDTH_B);
   localparam bit  DUAL    = (MODE != SINGLE_PORT) && !PACKED;
   localparam bit  FAMILY  = !DUAL || (((WIDTH_A % 9) == 0) == ((WIDTH_B % 9) == 0));
   localparam bit  MIX_OK  = (MODE != TRUE_DUAL) || (WIDTH_A == WIDTH_B)
                             || (WIDTH_A < 32 && WIDTH_B < 32);
   localparam bit  PACK_OK = !PACKED || (WIDTH_A <= 18 && WIDTH_B <= 18);
   localparam bit  LEGAL   = SHAPES && FAMILY && MIX_OK && PACK_OK;
   localparam bit  WR_A    = LEGAL;
   localparam bit  RD_A    = LEGAL && (PACKED || MODE != SIMPLE_DUAL);
   localparam bit  WR_B    = LEGAL && (PACKED || MODE == TRUE_DUAL);
   localparam bit  RD_B    = LEGAL && (PACKED || MODE != SINGLE_PORT);
   localparam int  OTHER_A = (MODE == TRUE_DUAL && !PACKED) ? WIDTH_B : WIDTH_A;
   localparam int  OTHER_B = (MODE == TRUE_DUAL && !PACKED) ? WIDTH_A : WIDTH_B;
   localparam bit  NEW_RD  = (RDW == RDW_NEW);
   localparam logic [9:0] BASE_B = PACKED ? `PACK_BASE : 10'h000;

   // Lane storage: 1024 lanes of 9 bits, the ninth bit kept as plain data.
   logic [8:0]          mem [`LANE_COUNT];
   logic [`MAX_W-1:0]   old_a;
   logic [`MAX_W-1:0]   old_b;

   wire  [9:0]          base_a;
   wire  [9:0]          base_b;
   wire  [`BE_W-1:0]    we_a;
   wire  [`BE_W-1:0]    we_b;
   wire  [8:0]          mask_a;
   wire  [8:0]          mask_b;
   wire  [`MAX_W-1:0]   wd_a;
   wire  [`MAX_W-1:0]   wd_b;
   wire  [8:0]          lane0_a = mem[base_a];

   ram_port #(
      .WIDTH    (WIDTH_A),
      .OTHER_W  (OTHER_A),
      .AW       (AW_A),
      .BASE     (10'h000),
      .NEW_DATA (NEW_RD),
      .OUT_REG  (OUT_REG_A),
      .WR_OK    (WR_A),
      .RD_OK    (RD_A)
   ) port_a (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .clken_in   (clken_in_a),
      .clken_out  (clken_out_a),
      .aclr       (aclr_a),
      .addr       (addr_a),
      .addr_stall (addr_stall_a),
      .wren       (wren_a),
      .rden       (rden_a),
      .be         (be_a),
      .din        (din_a),
      .old_word   (old_a),
      .lane_base  (base_a),
      .lane_we    (we_a),
      .lane_mask  (mask_a),
      .lane_wdata (wd_a),
      .q          (q_a)
   );

   ram_port #(
      .WIDTH    (WIDTH_B),
      .OTHER_W  (OTHER_B),
      .AW       (AW_B),
      .BASE     (BASE_B),
      .NEW_DATA (NEW_RD),
      .OUT_REG  (OUT_REG_B),
      .WR_OK    (WR_B),
      .RD_OK    (RD_B)
   ) port_b (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .clken_in   (clken_in_b),
      .clken_out  (clken_out_b),
      .aclr       (aclr_b),
      .addr       (addr_b),
      .addr_stall (addr_stall_b),
      .wren       (wren_b),
      .rden       (rden_b),
      .be         (be_b),
      .din        (din_b),
      .old_word   (old_b),
      .lane_base  (base_b),
      .lane_we    (we_b),
      .lane_mask  (mask_b),
      .lane_wdata (wd_b),
      .q          (q_b)
   );

   // Both ports see the array as it stood before this edge's writes.
   always_comb
   begin
      old_a = '0;
      old_b = '0;
      for (int k = 0; k < `MAX_LANES; k++)
      begin
         old_a[k*9 +: 9] = mem[base_a + 10'(k)];
         old_b[k*9 +: 9] = mem[base_b + 10'(k)];
      end
   end

   // The array has no reset. Port B's loop runs last, so it wins any shared lane
   // even when the two ports have different widths.
   always_ff @(posedge sys_clk)
   begin
      for (int k = 0; k < `MAX_LANES; k++)
      begin
         if (we_a[k])
            mem[base_a + 10'(k)] <= (mem[base_a + 10'(k)] & ~mask_a)
                                    | (wd_a[k*9 +: 9] & mask_a);
      end
      for (int k = 0; k < `MAX_LANES; k++)
      begin
         if (we_b[k])
            mem[base_b + 10'(k)] <= (mem[base_b + 10'(k)] & ~mask_b)
                                    | (wd_b[k*9 +: 9] & mask_b);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence masked_a_write;
      ce && clken_in_a && wren_a && !we_a[0] && (we_b == 4'h0);
   endsequence

   sequence idle_array;
      (we_a == 4'h0) && (we_b == 4'h0);
   endsequence

   sequence b_read_taken;
      RD_B && ((WIDTH_B % 9) == 0) && ce && clken_in_b && rden_b && (!NEW_RD || !wren_b);
   endsequence

   sequence b_out_step;
      OUT_REG_B && ce && clken_out_b;
   endsequence

   reset_clear_a: assert property (disable iff (1'b0) rst |=> (q_a == '0) && (q_b == '0))
      else $error("outputs not zero after reset");
   mask_keep_a: assert property (masked_a_write |=> mem[$past(base_a)] == $past(lane0_a))
      else $error("masked lane was overwritten");
   no_write_a: assert property (idle_array |=> mem[$past(base_a)] == $past(lane0_a))
      else $error("array changed without a write enable");
   freeze_array_a: assert property (!ce |-> (we_a == 4'h0) && (we_b == 4'h0))
      else $error("write issued while clock enable low");
   lane_order_a: assert property (ce && clken_in_a && wren_a && WR_A && WIDTH_A >= 16
                                  && (OTHER_A % 8 == 0 || OTHER_A % 9 == 0)
                                  |-> we_a == (be_a & 4'((1 << (WIDTH_A / 8)) - 1)))
      else $error("byte enable lanes out of order");
   direct_read_a: assert property (disable iff (rst || aclr_a)
                                   !OUT_REG_A && RD_A && ((WIDTH_A % 9) == 0) && ce && clken_in_a
                                   && rden_a && (!NEW_RD || !wren_a)
                                   |=> q_a == $past(old_a[WIDTH_A-1:0]))
      else $error("port A read did not return the stored word");
   registered_read_a: assert property (disable iff (rst || aclr_b)
                                       b_read_taken ##1 b_out_step
                                       |=> q_b == $past(old_b[WIDTH_B-1:0], 2))
      else $error("port B registered read did not return the stored word");

endmodule : block_ram
`default_nettype wire

/* File: include/ram_map.svh */
// Storage geometry, lane layout and lane masks of the embedded RAM block.
`ifndef RAM_MAP_SVH
`define RAM_MAP_SVH
`define DATA_BITS   8192
`define TOTAL_BITS  9216
`define LANE_COUNT  1024
`define LANE_AW     10
`define LANE_W      9
`define MAX_LANES   4
`define MAX_W       36
`define BE_W        4
`define BE_ALL      4'hF
`define PACK_BASE   10'h200
`define MASK_NINE   9'h1FF
`define MASK_EIGHT  9'h0FF
`endif

/* File: include/ram_pkg.sv */
// Types and configuration helpers shared by the RAM block and its port logic.
package ram_pkg;

   typedef enum logic [2:0]
   {
      SINGLE_PORT = 3'b001,
      SIMPLE_DUAL = 3'b010,
      TRUE_DUAL   = 3'b100
   } ram_mode_e;

   typedef enum logic [1:0]
   {
      RDW_OLD = 2'b01,
      RDW_NEW = 2'b10
   } rdw_e;

   function automatic bit shape_ok(input int w);
      return w inside {1, 2, 4, 8, 9, 16, 18, 32, 36};
   endfunction : shape_ok

endpackage : ram_pkg

/* File: core/ram_port.sv */
// Port logic: address register, lane steering, read mux and output registers.
`timescale 1ns/1ps
`default_nettype none
`include "ram_map.svh"

module ram_port
   import ram_pkg::*;
#(
   parameter int         WIDTH    = 36,
   parameter int         OTHER_W  = 36,
   parameter int         AW       = 8,
   parameter logic [9:0] BASE     = 10'h000,
   parameter bit         NEW_DATA = 1'b0,
   parameter bit         OUT_REG  = 1'b0,
   parameter bit         WR_OK    = 1'b1,
   parameter bit         RD_OK    = 1'b1
)
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               clken_in,
   input  wire logic               clken_out,
   input  wire logic               aclr,
   input  wire logic [AW-1:0]      addr,
   input  wire logic               addr_stall,
   input  wire logic               wren,
   input  wire logic               rden,
   input  wire logic [`BE_W-1:0]   be,
   input  wire logic [WIDTH-1:0]   din,
   input  wire logic [`MAX_W-1:0]  old_word,
   output logic      [9:0]         lane_base,
   output logic      [`BE_W-1:0]   lane_we,
   output logic      [8:0]         lane_mask,
   output logic      [`MAX_W-1:0]  lane_wdata,
   output logic      [WIDTH-1:0]   q
);

   localparam bit         NINE       = (WIDTH % 9) == 0;
   localparam int         LW         = NINE ? 9 : 8;
   localparam bit         SUB        = WIDTH < 8;
   localparam int         LANES      = SUB ? 1 : WIDTH / LW;
   localparam bit         BE_OK      = (WIDTH >= 16)
                                       && ((OTHER_W % 8) == 0 || (OTHER_W % 9) == 0);
   localparam logic [8:0] SUB_MASK   = 9'((1 << WIDTH) - 1);
   localparam logic [8:0] FULL_MASK  = NINE ? `MASK_NINE : `MASK_EIGHT;
   localparam logic [3:0] LANES_USED = 4'((1 << LANES) - 1);

   logic [AW-1:0]      addr_r;
   logic [WIDTH-1:0]   q_lat_r;
   logic [WIDTH-1:0]   q_reg_r;
   logic [`MAX_W-1:0]  old_p;
   logic [`MAX_W-1:0]  rd_mix;

   wire                in_go    = ce & clken_in;
   wire                out_go   = ce & clken_out;
   wire [AW-1:0]       eff_addr = addr_stall ? addr_r : addr;
   wire [15:0]         word_idx = 16'(eff_addr);
   wire [15:0]         bit_pos  = word_idx * 16'(WIDTH);
   wire [2:0]          bit_off  = SUB ? bit_pos[2:0] : 3'h0;
   wire [9:0]          first    = SUB ? bit_pos[12:3] : 10'(word_idx * 16'(LANES));
   wire                wr_go    = in_go & wren & WR_OK;
   wire                rd_go    = in_go & rden & RD_OK;
   // The mask comes straight from the pins only when BE_OK, else all lanes are enabled; it is not registered, so nothing can clear it.
   wire [`BE_W-1:0]    be_eff   = BE_OK ? be : `BE_ALL;
   wire [`MAX_W-1:0]   din_p    = `MAX_W'(din);
   wire [`MAX_W-1:0]   q_lat_p  = `MAX_W'(q_lat_r);

   assign lane_base = first + BASE;
   assign lane_we   = wr_go ? (be_eff & LANES_USED) : 4'h0;
   assign lane_mask = SUB ? (SUB_MASK << bit_off) : FULL_MASK;
   assign q         = OUT_REG ? q_reg_r : q_lat_r;

   always_comb
   begin
      old_p      = '0;
      lane_wdata = '0;
      for (int k = 0; k < LANES; k++)
      begin
         old_p[k*LW +: LW]     = old_word[k*9 +: LW];
         lane_wdata[k*9 +: 9]  = 9'(din_p[k*LW +: LW]);
      end
      if (SUB)
      begin
         old_p            = `MAX_W'((old_word[8:0] >> bit_off) & SUB_MASK);
         lane_wdata[8:0]  = 9'(din_p[7:0]) << bit_off;
      end
      rd_mix = old_p;
      for (int k = 0; k < LANES; k++)
      begin
         if (wr_go && be_eff[k] && NEW_DATA)
         begin
            rd_mix[k*LW +: LW] = din_p[k*LW +: LW];
         end
      end
   end

   // Only the address register and output stages clear asynchronously.
   always_ff @(posedge sys_clk or posedge rst or posedge aclr)
   begin
      if (rst || aclr)
         addr_r <= '0;
      else if (in_go)
         addr_r <= eff_addr;
   end

   always_ff @(posedge sys_clk or posedge rst or posedge aclr)
   begin
      if (rst || aclr)
         q_lat_r <= '0;
      else if (rd_go)
         q_lat_r <= rd_mix[WIDTH-1:0];
   end

   always_ff @(posedge sys_clk or posedge rst or posedge aclr)
   begin
      if (rst || aclr)
         q_reg_r <= '0;
      else if (out_go)
         q_reg_r <= q_lat_r;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || aclr);

   sequence full_write_read;
      wr_go && rd_go && (lane_we == LANES_USED);
   endsequence

   stall_hold_a: assert property (in_go && addr_stall |=> addr_r == $past(addr_r))
      else $error("address moved while stalled");
   freeze_hold_a: assert property (!in_go |=> $stable(q_lat_r) && $stable(addr_r))
      else $error("port state changed with clock enable low");
   rden_hold_a: assert property (in_go && !rden |=> $stable(q_lat_r))
      else $error("read data changed with read enable low");
   new_data_a: assert property ((NEW_DATA and full_write_read) |=> q_lat_r == $past(din))
      else $error("new data mode did not return written word");
   old_data_a: assert property ((!NEW_DATA and full_write_read)
                                |=> q_lat_r == $past(old_p[WIDTH-1:0]))
      else $error("old data mode did not return stored word");
   masked_lane_a: assert property (!SUB && rd_go && wr_go && !lane_we[0]
                                   |=> q_lat_p[LW-1:0] == $past(old_p[LW-1:0]))
      else $error("masked lane did not show stored byte");
   out_delay_a: assert property (out_go |=> q_reg_r == $past(q_lat_r))
      else $error("output register is not one cycle behind");

endmodule : ram_port
`default_nettype wire

/* File: verif/fabric_user_model.sv */
// Shadow of the fabric logic's view of the RAM: it tracks storage and the read data it expects.
`timescale 1ns/1ps
`default_nettype none

module fabric_user_model
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        clken_in_a,
   input  wire logic        clken_in_b,
   input  wire logic        clken_out_b,
   input  wire logic        aclr_a,
   input  wire logic        aclr_b,
   input  wire logic [7:0]  addr_a,
   input  wire logic [7:0]  addr_b,
   input  wire logic        addr_stall_a,
   input  wire logic        addr_stall_b,
   input  wire logic        wren_a,
   input  wire logic        wren_b,
   input  wire logic        rden_a,
   input  wire logic        rden_b,
   input  wire logic [3:0]  be_a,
   input  wire logic [3:0]  be_b,
   input  wire logic [35:0] din_a,
   input  wire logic [35:0] din_b,
   output logic      [35:0] exp_q_a,
   output logic      [35:0] exp_q_b
);
   logic [35:0] mem_r [0:255];
   logic [7:0]  ara_r;
   logic [7:0]  arb_r;
   logic [35:0] latch_b_r;
   logic [35:0] wa;
   wire  [7:0]  ea = addr_stall_a ? ara_r : addr_a;
   wire  [7:0]  eb = addr_stall_b ? arb_r : addr_b;

   function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                         input logic [3:0] be);
      merge = old;
      for (int k = 0; k < 4; k++)
      begin
         if (be[k])
            merge[9*k +: 9] = nw[9*k +: 9];
      end
   endfunction : merge

   // Port B lands after port A so that it wins a shared lane written on the same edge.
   always @(posedge sys_clk)
   begin
      if (ce)
      begin
         wa = merge(mem_r[ea], din_a, be_a);
         if (clken_in_a && wren_a)
            mem_r[ea] <= wa;
         if (clken_in_b && wren_b)
            mem_r[eb] <= merge((clken_in_a && wren_a && ea == eb) ? wa : mem_r[eb],
                               din_b, be_b);
      end
   end

   always_ff @(posedge sys_clk or posedge rst or posedge aclr_a)
   begin
      if (rst || aclr_a)
      begin
         ara_r   <= 8'h00;
         exp_q_a <= 36'h0;
      end
      else if (ce && clken_in_a)
      begin
         ara_r <= ea;
         if (rden_a)
            exp_q_a <= mem_r[ea];
      end
   end

   always_ff @(posedge sys_clk or posedge rst or posedge aclr_b)
   begin
      if (rst || aclr_b)
      begin
         arb_r     <= 8'h00;
         latch_b_r <= 36'h0;
         exp_q_b   <= 36'h0;
      end
      else if (ce)
      begin
         if (clken_in_b)
            arb_r <= eb;
         if (clken_in_b && rden_b)
            latch_b_r <= mem_r[eb];
         if (clken_out_b)
            exp_q_b <= latch_b_r;
      end
   end
endmodule : fabric_user_model

`default_nettype wire

/* File: verif/test_block_ram.sv */
// Self-checking bench for the block RAM as a true dual-port 256x36 with port B registered.
`timescale 1ns/1ps
`default_nettype none

module test_block_ram;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b0;
   logic        clken_in_a = 1'b1, clken_in_b = 1'b1, clken_out_a = 1'b1, clken_out_b = 1'b1;
   logic        aclr_a = 1'b0, aclr_b = 1'b0, addr_stall_a = 1'b0, addr_stall_b = 1'b0;
   logic        wren_a = 1'b0, wren_b = 1'b0, rden_a = 1'b0, rden_b = 1'b0;
   logic [7:0]  addr_a = 8'h00, addr_b = 8'h00;
   logic [3:0]  be_a = 4'hF, be_b = 4'hF;
   logic [35:0] din_a = 36'h0, din_b = 36'h0, w;
   logic [35:0] q_a, q_b, exp_q_a, exp_q_b;
   integer      seed = 32'h6EF2;
   int          fails = 0, total_checks = 0, cycles = 0;

   block_ram #(.OUT_REG_B(1'b1)) i_block_ram
   (
      .sys_clk, .rst, .ce, .clken_in_a, .clken_out_a, .aclr_a, .addr_a, .addr_stall_a,
      .wren_a, .rden_a, .be_a, .din_a, .q_a, .clken_in_b, .clken_out_b, .aclr_b, .addr_b,
      .addr_stall_b, .wren_b, .rden_b, .be_b, .din_b, .q_b
   );

   fabric_user_model i_fabric_user_model
   (
      .sys_clk, .rst, .ce, .clken_in_a, .clken_in_b, .clken_out_b, .aclr_a, .aclr_b,
      .addr_a, .addr_b, .addr_stall_a, .addr_stall_b, .wren_a, .wren_b, .rden_a, .rden_b,
      .be_a, .be_b, .din_a, .din_b, .exp_q_a, .exp_q_b
   );

   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end

   function automatic logic [35:0] pat(input logic [7:0] i);
      return {4'hA, i, ~i, i ^ 8'h5A, 8'h3C};
   endfunction : pat

   task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Inputs change only at the falling edge, after both outputs have been compared.
   task automatic tick;
      @(negedge sys_clk);
      check("q_a", exp_q_a, q_a);
      check("q_b", exp_q_b, q_b);
   endtask : tick

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fails++;
         $display("CHECK FAILED timeout expected done seen running");
         finish_test();
      end
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      check("q_a after reset", 36'h0, q_a);
      check("q_b after reset", 36'h0, q_b);
      ce = 1'b1;
      wren_a = 1'b1;
      for (int i = 0; i < 256; i++)
      begin
         tick();
         addr_a = i[7:0];
         din_a = pat(i[7:0]);
      end
      tick();
      wren_a = 1'b0;
      rden_a = 1'b1;
      addr_a = 8'h05;
      tick();
      check("q_a word", pat(8'h05), q_a);
      // Every mask pattern, with the bench tracking which lanes should change.
      w = pat(8'h09);
      addr_a = 8'h09;
      wren_a = 1'b1;
      for (int m = 0; m < 16; m++)
      begin
         be_a = m[3:0];
         din_a = {m[3:0], 32'($random(seed))};
         tick();
         check("q_a during write", w, q_a);
         for (int k = 0; k < 4; k++)
         begin
            if (m[k])
               w[9*k +: 9] = din_a[9*k +: 9];
         end
      end
      wren_a = 1'b0;
      be_a = 4'hF;
      tick();
      tick();
      check("lanes", w, q_a);
      for (int f = 0; f < 2; f++)
      begin
         ce = f[0];
         clken_in_a = !f[0];
         addr_a = 8'h03;
         din_a = ~pat(8'h03);
         wren_a = 1'b1;
         tick();
         ce = 1'b1;
         clken_in_a = 1'b1;
         wren_a = 1'b0;
         tick();
         check("frozen write", pat(8'h03), q_a);
      end
      addr_a = 8'h07;
      tick();
      addr_a = 8'h14;
      addr_stall_a = 1'b1;
      tick();
      check("stalled address", pat(8'h07), q_a);
      addr_stall_a = 1'b0;
      rden_b = 1'b1;
      addr_b = 8'h0B;
      tick();
      rden_b = 1'b0;
      check("q_b one edge", 36'h0, q_b);
      tick();
      check("q_b two edges", pat(8'h0B), q_b);
      rden_a = 1'b0;
      aclr_a = 1'b1;
      #1;
      check("q_a cleared", 36'h0, q_a);
      check("q_b kept", pat(8'h0B), q_b);
      tick();
      aclr_a = 1'b0;
      aclr_b = 1'b1;
      #1;
      check("q_b cleared", 36'h0, q_b);
      tick();
      aclr_b = 1'b0;
      // A narrow address range makes the two ports collide often.
      for (int n = 0; n < 2000; n++)
      begin
         tick();
         addr_a = {5'h00, 3'($random(seed))};
         addr_b = {5'h00, 3'($random(seed))};
         {addr_stall_a, addr_stall_b} = 2'($random(seed));
         {wren_a, rden_a, wren_b, rden_b, be_a, be_b} = 12'($random(seed));
         din_a = {4'h5, 32'($random(seed))};
         din_b = {4'hA, 32'($random(seed))};
         ce = 3'($random(seed)) != 3'h0;
         clken_in_a = 2'($random(seed)) != 2'h0;
         clken_in_b = 2'($random(seed)) != 2'h0;
         clken_out_b = 2'($random(seed)) != 2'h0;
      end
      tick();
      rst = 1'b1;
      tick();
      rst = 1'b0;
      check("q_a after second reset", 36'h0, q_a);
      check("q_b after second reset", 36'h0, q_b);
      tick();
      finish_test();
   end
endmodule : test_block_ram

`default_nettype wire
